// *** fmpr_top.sv ***
// Protected flash mode control, protect command and status registers
`timescale 1ns/10ps
`default_nettype none

module fmpr_top
    import fmpr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        st_en,
    input  wire logic [15:0] st_addr,
    input  wire logic [7:0]  st_data,
    input  wire logic        st_bit,
    input  wire logic [2:0]  st_bit_sel,
    input  wire logic        rd_en,
    input  wire logic [15:0] rd_addr,
    output logic      [7:0]  rd_data,
    input  wire logic        prog_mode_pin,
    input  wire logic        onboard_strap,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] fw_addr,
    output logic      [15:0] flash_addr,
    output logic             flash_prog_en,
    output logic             fw_call_en,
    output logic             protect_error_flag
);
    import fmpr_pkg::*;

    // ========================================================
    // Decoding helpers

    // Byte that a store leaves in a register: whole byte or one bit
    function automatic logic [7:0] store_value(
        input logic [7:0] cur,
        input logic [7:0] data,
        input logic       bit_op,
        input logic [2:0] sel
    );
        logic [7:0] v;
        v = data;
        if (bit_op) begin
            v      = cur;
            v[sel] = data[sel];
        end
        return v;
    endfunction

    // Address match used for both the store and the load path
    function automatic logic hit(
        input logic [15:0] a,
        input logic [15:0] reg_addr
    );
        return a == reg_addr;
    endfunction

    // ========================================================
    // Pin synchronisation and strap capture

    logic [FMPR_SYNC_W-1:0] pins_async;
    logic [FMPR_SYNC_W-1:0] pins_sync;
    logic                   pin_level;
    logic                   onboard_reg;
    logic                   onboard_next;
    logic                   strap_done_reg;
    logic                   strap_done_next;

    assign pins_async[FMPR_SYNC_PIN] = prog_mode_pin;
    assign pins_async[FMPR_SYNC_OBM] = onboard_strap;

    fmpr_sync u_sync (
        .clk      (clk),
        .async_in (pins_async),
        .sync_out (pins_sync)
    );

    assign pin_level = pins_sync[FMPR_SYNC_PIN];

    // Strap is frozen on the first edge after reset is released
    always_comb begin
        onboard_next    = onboard_reg;
        strap_done_next = strap_done_reg;
        if (!strap_done_reg) begin
            onboard_next    = pins_sync[FMPR_SYNC_OBM];
            strap_done_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            onboard_reg    <= 1'b0;
            strap_done_reg <= 1'b0;
        end else begin
            onboard_reg    <= onboard_next;
            strap_done_reg <= strap_done_next;
        end
    end

    // ========================================================
    // Store decode

    logic       st_cmd;
    logic       st_ctrl;
    logic       st_stat;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;
    logic [7:0] ctrl_wval;
    logic [7:0] stat_wval;

    assign st_cmd  = st_en && hit(st_addr, FMPR_ADDR_CMD);
    assign st_ctrl = st_en && hit(st_addr, FMPR_ADDR_CTRL);
    assign st_stat = st_en && hit(st_addr, FMPR_ADDR_STAT);

    assign ctrl_wval = store_value(ctrl_view, st_data, st_bit, st_bit_sel);
    assign stat_wval = store_value(stat_view, st_data, st_bit, st_bit_sel);

    // ========================================================
    // Unlock tracker

    fmpr_state_e state_reg;
    fmpr_state_e state_next;
    logic [7:0]  target_reg;
    logic [7:0]  target_next;
    logic        seq_err;
    logic        commit;

    // Every store is judged; a store elsewhere mid-sequence breaks it
    always_comb begin
        state_next  = state_reg;
        target_next = target_reg;
        seq_err     = 1'b0;
        commit      = 1'b0;
        if (st_en) begin
            case (state_reg)
                FMPR_IDLE: begin
                    if (st_cmd) begin
                        if (!st_bit && st_data == FMPR_KEY) begin
                            state_next = FMPR_KEYED;
                        end else begin
                            seq_err = 1'b1;
                        end
                    end else if (st_ctrl) begin
                        seq_err = 1'b1;
                    end
                end
                FMPR_KEYED: begin
                    if (st_ctrl) begin
                        target_next = ctrl_wval;
                        state_next  = FMPR_GOT_VALUE;
                    end else begin
                        seq_err    = 1'b1;
                        state_next = FMPR_IDLE;
                    end
                end
                FMPR_GOT_VALUE: begin
                    if (st_ctrl && ctrl_wval == ~target_reg) begin
                        state_next = FMPR_GOT_INV;
                    end else begin
                        seq_err    = 1'b1;
                        state_next = FMPR_IDLE;
                    end
                end
                FMPR_GOT_INV: begin
                    if (st_ctrl && ctrl_wval == target_reg) begin
                        commit = 1'b1;
                    end else begin
                        seq_err = 1'b1;
                    end
                    state_next = FMPR_IDLE;
                end
                default: begin
                    state_next = FMPR_IDLE;
                end
            endcase
        end
    end

    // Target byte has no reset need; cleared anyway for clean reads
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg  <= FMPR_IDLE;
            target_reg <= 8'h00;
        end else begin
            state_reg  <= state_next;
            target_reg <= target_next;
        end
    end

    // ========================================================
    // Control register

    // load on good repeat; otherwise kept
    always_comb begin
        ctrl_next = ctrl_reg;
        if (commit) begin
            ctrl_next = target_reg & FMPR_CTRL_WR_MASK;
        end
    end

    // reset value, pin bit added live
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= FMPR_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // read-only pin level in bit 2
    always_comb begin
        ctrl_view                    = ctrl_reg & FMPR_CTRL_WR_MASK;
        ctrl_view[FMPR_CTRL_PIN_LVL] = pin_level;
    end

    // ========================================================
    // Status register

    logic clr_err;

    assign clr_err = st_stat && !stat_wval[FMPR_STAT_ERR];

    fmpr_err_flag u_err (
        .clk      (clk),
        .rst      (rst),
        .set_err  (seq_err),
        .clr_err  (clr_err),
        .err_flag (protect_error_flag)
    );

    // only the flag bit is live
    always_comb begin
        stat_view                = FMPR_STAT_RESET;
        stat_view[FMPR_STAT_ERR] = protect_error_flag;
    end

    // ========================================================
    // Load path, answered one cycle after the request

    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_en) begin
            if (hit(rd_addr, FMPR_ADDR_CTRL)) begin
                rd_data_next = ctrl_view;
            end else if (hit(rd_addr, FMPR_ADDR_STAT)) begin
                rd_data_next = stat_view;
            end else begin
                rd_data_next = FMPR_RD_NONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_reg <= FMPR_RD_NONE;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

    // ========================================================
    // Flash side controls

    logic [1:0] mode_eff;
    logic       prog_en_reg;
    logic       prog_en_next;
    logic       fw_call_reg;
    logic       fw_call_next;

    assign mode_eff = onboard_reg ? FMPR_MODE_NORMAL :
                      {ctrl_reg[FMPR_CTRL_MODE_HI],
                       ctrl_reg[FMPR_CTRL_MODE_LO]};

    always_comb begin
        // disable bit; pin must be high
        prog_en_next = !ctrl_reg[FMPR_CTRL_PROG_DIS] && pin_level;
        // firmware call only in mode 01
        fw_call_next = mode_eff == FMPR_MODE_SELF;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_en_reg <= 1'b0;
            fw_call_reg <= 1'b0;
        end else begin
            prog_en_reg <= prog_en_next;
            fw_call_reg <= fw_call_next;
        end
    end

    assign flash_prog_en = prog_en_reg;
    assign fw_call_en    = fw_call_reg;

    // address source; kept combinational to add no fetch latency
    assign flash_addr = mode_eff[1] ? fw_addr : cpu_addr;

endmodule

`default_nettype wire

// *** fmpr_pkg.sv ***
// Package of addresses, field layouts, reset values and states for the block
package fmpr_pkg;

    // ========================================================
    // Store and load addresses
    localparam logic [15:0] FMPR_ADDR_CMD  = 16'hFFC0;
    localparam logic [15:0] FMPR_ADDR_CTRL = 16'hFFC4;
    localparam logic [15:0] FMPR_ADDR_STAT = 16'hFFC2;

    // ========================================================
    // Field positions of flash_mode_ctrl
    localparam int FMPR_CTRL_MODE_LO  = 0;
    localparam int FMPR_CTRL_MODE_HI  = 1;
    localparam int FMPR_CTRL_PIN_LVL  = 2;
    localparam int FMPR_CTRL_PROG_DIS = 3;

    // Bits that the protected sequence may load
    localparam logic [7:0] FMPR_CTRL_WR_MASK = 8'h0B;

    // Stored part of the control register after reset
    localparam logic [7:0] FMPR_CTRL_RESET   = 8'h08;

    // ========================================================
    // Field positions and reset value of flash_stat
    localparam int         FMPR_STAT_ERR     = 0;
    localparam logic [7:0] FMPR_STAT_RESET   = 8'h00;

    // ========================================================
    // Sequence key and mode field codes
    localparam logic [7:0] FMPR_KEY          = 8'hA5;
    localparam logic [1:0] FMPR_MODE_NORMAL  = 2'h0;
    localparam logic [1:0] FMPR_MODE_SELF    = 2'h1;

    // Number of pin levels brought through the synchroniser
    localparam int FMPR_SYNC_W   = 2;
    localparam int FMPR_SYNC_PIN = 0;
    localparam int FMPR_SYNC_OBM = 1;

    // Read value of the write-only command register and of holes
    localparam logic [7:0] FMPR_RD_NONE = 8'h00;

    // ========================================================
    // Unlock tracker states
    typedef enum logic [1:0] {
        FMPR_IDLE,
        FMPR_KEYED,
        FMPR_GOT_VALUE,
        FMPR_GOT_INV
    } fmpr_state_e;

endpackage

// *** fmpr_sync.sv ***
// Two-flop synchroniser for the pin levels entering the block
`timescale 1ns/10ps
`default_nettype none

module fmpr_sync
    import fmpr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [FMPR_SYNC_W-1:0] async_in,
    output logic      [FMPR_SYNC_W-1:0] sync_out
);
    import fmpr_pkg::*;

    logic [FMPR_SYNC_W-1:0] meta_reg;
    logic [FMPR_SYNC_W-1:0] meta_next;
    logic [FMPR_SYNC_W-1:0] sync_reg;
    logic [FMPR_SYNC_W-1:0] sync_next;

    // ========================================================
    // Stage chain; only the second stage reads the first
    genvar g;
    generate
        for (g = 0; g < FMPR_SYNC_W; g++) begin : g_bit
            always_comb begin
                meta_next[g] = async_in[g];
                sync_next[g] = meta_reg[g];
            end
        end
    endgenerate

    // No reset: stages keep filling during reset so the strap is valid
    // at the first edge after release
    always_ff @(posedge clk) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// *** fmpr_err_flag.sv ***
// Sticky protection error flag held in flash_stat
`timescale 1ns/10ps
`default_nettype none

module fmpr_err_flag (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic set_err,
    input  wire logic clr_err,
    output logic      err_flag
);
    import fmpr_pkg::*;

    logic flag_reg;
    logic flag_next;

    // ========================================================
    // Set beats clear so an error in the clearing cycle survives
    always_comb begin
        flag_next = flag_reg;
        if (clr_err) begin
            flag_next = 1'b0;
        end
        if (set_err) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= FMPR_STAT_RESET[FMPR_STAT_ERR];
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign err_flag = flag_reg;

endmodule

`default_nettype wire

// *** fmpr_cpu.sv ***
// CPU store and load path plus programming pins facing the block
`timescale 1ns/10ps
`default_nettype none

module fmpr_cpu (
    input  wire logic        clk,
    input  wire logic [7:0]  rd_data,
    output logic             st_en,
    output logic [15:0]      st_addr,
    output logic [7:0]       st_data,
    output logic             st_bit,
    output logic [2:0]       st_bit_sel,
    output logic             rd_en,
    output logic [15:0]      rd_addr,
    output logic             prog_mode_pin,
    output logic             onboard_strap
);
    import fmpr_pkg::*;

    // ==========================================================
    // Idle bus at time zero
    initial begin
        st_en = 1'b0;
        st_addr = 16'h0000;
        st_data = 8'h00;
        st_bit = 1'b0;
        st_bit_sel = 3'h0;
        rd_en = 1'b0;
        rd_addr = 16'h0000;
        prog_mode_pin = 1'b0;
        onboard_strap = 1'b0;
    end

    // One store; released address and data lines show the inverse so stale data never helps
    task automatic store(input logic [15:0] a, input logic [7:0] d,
                         input logic b, input logic [2:0] s);
        @(posedge clk);
        st_en <= 1'b1;
        st_addr <= a;
        st_data <= d;
        st_bit <= b;
        st_bit_sel <= s;
        @(posedge clk);
        st_en <= 1'b0;
        st_addr <= ~a;
        st_data <= ~d;
    endtask

    // One load; answer taken once the edge after the strobe has landed
    task automatic load(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        #1;
        d = rd_data;
    endtask

    // keyed change, caller runs from RAM
    task automatic write_ctrl(input logic [7:0] v);
        store(FMPR_ADDR_CMD, FMPR_KEY, 1'b0, 3'h0);
        store(FMPR_ADDR_CTRL, v, 1'b0, 3'h0);
        store(FMPR_ADDR_CTRL, ~v, 1'b0, 3'h0);
        store(FMPR_ADDR_CTRL, v, 1'b0, 3'h0);
    endtask

    // Pin levels change just after an edge
    task automatic set_pins(input logic p, input logic o);
        @(posedge clk);
        prog_mode_pin <= p;
        onboard_strap <= o;
    endtask
endmodule
`default_nettype wire

// *** fmpr_sva.sv ***
// Checker watching the ports of the protected flash mode block
`timescale 1ns/10ps
`default_nettype none

module fmpr_sva
    import fmpr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        st_en,
    input wire logic [15:0] st_addr,
    input wire logic [7:0]  st_data,
    input wire logic        st_bit,
    input wire logic        rd_en,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0]  rd_data,
    input wire logic        prog_mode_pin,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] flash_addr,
    input wire logic        flash_prog_en,
    input wire logic        fw_call_en,
    input wire logic        protect_error_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Error flag
    property p_bad_key;
        st_en && st_addr == FMPR_ADDR_CMD && (st_bit || st_data != FMPR_KEY)
            |=> protect_error_flag;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key left flag clear");
    property p_sticky;
        protect_error_flag && !(st_en && st_addr == FMPR_ADDR_STAT)
            |=> protect_error_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without status store");
    property p_rise;
        $rose(protect_error_flag) |-> $past(st_en);
    endproperty
    a_rise: assert property (p_rise)
        else $error("flag rose without a store");

    // ==========================================================
    // Load answers, one cycle after the strobe
    property p_rd_cmd;
        rd_en && rd_addr == FMPR_ADDR_CMD |=> rd_data == FMPR_RD_NONE;
    endproperty
    a_rd_cmd: assert property (p_rd_cmd)
        else $error("command register readable");
    property p_rd_stat;
        rd_en && rd_addr == FMPR_ADDR_STAT && !st_en
            |=> rd_data == {7'h00, $past(protect_error_flag)};
    endproperty
    a_rd_stat: assert property (p_rd_stat)
        else $error("status readback wrong");
    property p_pin_rd;
        $stable(prog_mode_pin)[*4] ##0 (rd_en && rd_addr == FMPR_ADDR_CTRL)
            |=> rd_data[FMPR_CTRL_PIN_LVL] == $past(prog_mode_pin);
    endproperty
    a_pin_rd: assert property (p_pin_rd)
        else $error("pin level bit wrong");

    // ==========================================================
    // Flash side; sync delay covered by four low samples
    property p_prog_pin;
        (!prog_mode_pin)[*4] |=> !flash_prog_en;
    endproperty
    a_prog_pin: assert property (p_prog_pin)
        else $error("programming allowed with pin low");
    property p_addr_mux;
        fw_call_en |-> $past(flash_addr) == $past(cpu_addr);
    endproperty
    a_addr_mux: assert property (p_addr_mux)
        else $error("mode 01 not on cpu address");

    c_err: cover property ($rose(protect_error_flag));
    c_prog: cover property ($rose(flash_prog_en));
    c_fw: cover property ($rose(fw_call_en));
endmodule
`default_nettype wire

// *** flash_mode_protected_regs_tb.sv ***
// Self-checking testbench for the protected flash mode registers
`timescale 1ns/10ps
`default_nettype none

module flash_mode_protected_regs_tb;
    import fmpr_pkg::*;
    logic        clk;
    logic        rst;
    logic        st_en;
    logic [15:0] st_addr;
    logic [7:0]  st_data;
    logic        st_bit;
    logic [2:0]  st_bit_sel;
    logic        rd_en;
    logic [15:0] rd_addr;
    logic [7:0]  rd_data;
    logic        prog_mode_pin;
    logic        onboard_strap;
    logic [15:0] cpu_addr;
    logic [15:0] fw_addr;
    logic [15:0] flash_addr;
    logic        flash_prog_en;
    logic        fw_call_en;
    logic        protect_error_flag;
    int          err_total;
    int          num_checks;

    fmpr_top u_fmpr_top (.clk(clk), .rst(rst), .st_en(st_en),
        .st_addr(st_addr), .st_data(st_data), .st_bit(st_bit),
        .st_bit_sel(st_bit_sel), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .prog_mode_pin(prog_mode_pin),
        .onboard_strap(onboard_strap), .cpu_addr(cpu_addr),
        .fw_addr(fw_addr), .flash_addr(flash_addr),
        .flash_prog_en(flash_prog_en), .fw_call_en(fw_call_en),
        .protect_error_flag(protect_error_flag));
    fmpr_cpu u_fmpr_cpu (.clk(clk), .rd_data(rd_data), .st_en(st_en),
        .st_addr(st_addr), .st_data(st_data), .st_bit(st_bit),
        .st_bit_sel(st_bit_sel), .rd_en(rd_en), .rd_addr(rd_addr),
        .prog_mode_pin(prog_mode_pin), .onboard_strap(onboard_strap));

    // ==========================================================
    // Clock and helpers
    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(string n, logic [15:0] a, logic [7:0] e);
        logic [7:0] v;
        u_fmpr_cpu.load(a, v);
        chk(n, {8'h00, e}, {8'h00, v});
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Reset held two cycles, then time for the synchronisers
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(4);
    endtask
    // Flag must be set, control kept, then a bit store of 0 clears it
    task automatic expect_err(string n, logic [7:0] ctrl);
        rdchk(n, FMPR_ADDR_STAT, 8'h01);
        rdchk("ctrl kept", FMPR_ADDR_CTRL, ctrl);
        u_fmpr_cpu.store(FMPR_ADDR_STAT, 8'h00, 1'b1, 3'h0);
        rdchk("flag cleared", FMPR_ADDR_STAT, 8'h00);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rdchk("ctrl user", FMPR_ADDR_CTRL, 8'h08);
        rdchk("stat", FMPR_ADDR_STAT, 8'h00);
        rdchk("cmd", FMPR_ADDR_CMD, 8'h00);
        u_fmpr_cpu.set_pins(1'b1, 1'b0);
        settle(4);
        rdchk("ctrl pin", FMPR_ADDR_CTRL, 8'h0C);
    endtask
    task automatic t_sequence();
        u_fmpr_cpu.store(FMPR_ADDR_CMD, FMPR_KEY, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h05, 1'b0, 3'h0);
        rdchk("first value", FMPR_ADDR_CTRL, 8'h0C);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'hFA, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h05, 1'b0, 3'h0);
        rdchk("final value", FMPR_ADDR_CTRL, 8'h05);
        settle(1);
        chk("prog en", 16'h0001, {15'h0000, flash_prog_en});
        chk("fw call", 16'h0001, {15'h0000, fw_call_en});
        chk("addr cpu", cpu_addr, flash_addr);
        chk("no error", 16'h0000, {15'h0000, protect_error_flag});
    endtask
    task automatic t_errors();
        u_fmpr_cpu.write_ctrl(8'h01);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h01, 1'b0, 3'h0);
        expect_err("no key", 8'h05);
        u_fmpr_cpu.store(FMPR_ADDR_CMD, 8'h5A, 1'b0, 3'h0);
        expect_err("bad key", 8'h05);
        u_fmpr_cpu.store(FMPR_ADDR_CMD, FMPR_KEY, 1'b1, 3'h5);
        expect_err("bit key", 8'h05);
        u_fmpr_cpu.store(FMPR_ADDR_CMD, FMPR_KEY, 1'b0, 3'h0);
        u_fmpr_cpu.store(16'h0010, 8'h00, 1'b0, 3'h0);
        expect_err("foreign", 8'h05);
        u_fmpr_cpu.store(FMPR_ADDR_CMD, FMPR_KEY, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h01, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h01, 1'b0, 3'h0);
        expect_err("bad inverse", 8'h05);
        u_fmpr_cpu.store(FMPR_ADDR_CMD, FMPR_KEY, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h01, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'hFE, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h00, 1'b0, 3'h0);
        expect_err("bad repeat", 8'h05);
        u_fmpr_cpu.store(FMPR_ADDR_CMD, FMPR_KEY, 1'b0, 3'h0);
        u_fmpr_cpu.store(FMPR_ADDR_CTRL, 8'h01, 1'b0, 3'h0);
        u_fmpr_cpu.write_ctrl(8'h01);
        expect_err("key again", 8'h05);
    endtask
    task automatic t_sticky();
        u_fmpr_cpu.store(FMPR_ADDR_CMD, 8'h00, 1'b0, 3'h0);
        u_fmpr_cpu.write_ctrl(8'h02);
        rdchk("ctrl 02", FMPR_ADDR_CTRL, 8'h06);
        rdchk("sticky", FMPR_ADDR_STAT, 8'h01);
        chk("addr fw", fw_addr, flash_addr);
        chk("fw call off", 16'h0000, {15'h0000, fw_call_en});
        u_fmpr_cpu.store(FMPR_ADDR_STAT, 8'h01, 1'b0, 3'h0);
        rdchk("write 1", FMPR_ADDR_STAT, 8'h01);
        u_fmpr_cpu.store(FMPR_ADDR_STAT, 8'h00, 1'b0, 3'h0);
        rdchk("write 0", FMPR_ADDR_STAT, 8'h00);
        u_fmpr_cpu.set_pins(1'b0, 1'b0);
        settle(5);
        chk("pin low", 16'h0000, {15'h0000, flash_prog_en});
        u_fmpr_cpu.set_pins(1'b1, 1'b0);
        u_fmpr_cpu.write_ctrl(8'h08);
        settle(5);
        chk("disabled", 16'h0000, {15'h0000, flash_prog_en});
    endtask
    // On-board strap held across a fresh reset
    task automatic t_onboard();
        u_fmpr_cpu.set_pins(1'b1, 1'b1);
        settle(3);
        do_reset();
        rdchk("ctrl board", FMPR_ADDR_CTRL, 8'h0C);
        u_fmpr_cpu.write_ctrl(8'h03);
        settle(2);
        chk("board fw", 16'h0000, {15'h0000, fw_call_en});
        chk("board addr", cpu_addr, flash_addr);
    endtask

    // ==========================================================
    // Closing and main sequence
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        cpu_addr = 16'h1234;
        fw_addr = 16'hABCD;
        err_total = 0;
        num_checks = 0;
        // Reset high from time zero, released after two edges
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle(4);
        t_reset();
        t_sequence();
        t_errors();
        t_sticky();
        t_onboard();
        close_out();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        close_out();
    end
endmodule

bind fmpr_top fmpr_sva u_fmpr_sva (.clk(clk), .rst(rst), .st_en(st_en),
    .st_addr(st_addr), .st_data(st_data), .st_bit(st_bit),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .prog_mode_pin(prog_mode_pin), .cpu_addr(cpu_addr),
    .flash_addr(flash_addr), .flash_prog_en(flash_prog_en),
    .fw_call_en(fw_call_en), .protect_error_flag(protect_error_flag));
`default_nettype wire
